/* File: bench/pcrb_assertions.sv */
module pcrb_checker
import pcrb_pkg::*;
#(
   parameter logic [3:0] MODEL = 4'h3,
   parameter logic [63:0] PLATFORM_ID_VAL = 64'h0
)
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [63:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [63:0] reg_rdata_out,
   input wire logic reg_err_out,
   input wire logic sys_mgmt_irq_strap_pin_n_in,
   input wire logic init_strap_pin_n_in,
   input wire logic [63:0] cycle_count_out,
   input wire logic [63:0] interrupt_ctrl_base_out,
   input wire logic [63:0] hard_poweron_config_out
);
   logic [63:0] wd_q;
   logic full;
   logic wc;
   assign full = MODEL == PCRB_MODEL_FULL_A || MODEL == PCRB_MODEL_FULL_B;
   assign wc = reg_wr_in && reg_addr_in == PCRB_CYC_IDX;
   always_ff @(posedge core_clk_in)
   begin
      wd_q <= reg_wdata_in;
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_cyc_low_half: assert property (
      wc |=> cycle_count_out[31:0] == wd_q[31:0]) else $error("low half");
   chk_cyc_high_clear: assert property (
      wc && !full |=> cycle_count_out[63:32] == 32'h0) else $error("high");
   chk_cyc_full_write: assert property (
      wc && full |=> cycle_count_out == wd_q) else $error("full write");
   chk_plat_read: assert property (
      reg_rd_in && reg_addr_in == PCRB_PLAT_IDX |=>
      reg_rdata_out == PLATFORM_ID_VAL) else $error("identity");
   chk_icb_write: assert property (
      reg_wr_in && reg_addr_in == PCRB_ICB_IDX |=>
      interrupt_ctrl_base_out == wd_q) else $error("icb");
   chk_hpc_rw_bits: assert property (
      reg_wr_in && reg_addr_in == PCRB_HPC_IDX |=>
      hard_poweron_config_out[63:2] == wd_q[63:2]) else $error("hpc");
   chk_strap_held: assert property (
      $past(rst_n_in, 2) && $past(rst_n_in) |->
      $stable(hard_poweron_config_out[1:0])) else $error("strap moved");
   chk_strap_capture: assert property (
      $rose(rst_n_in) |=> hard_poweron_config_out[1:0] ==
      {!$past(init_strap_pin_n_in), !$past(sys_mgmt_irq_strap_pin_n_in)})
      else $error("strap capture");
endmodule
bind pcrb_top pcrb_checker #(.MODEL(MODEL),
   .PLATFORM_ID_VAL(PLATFORM_ID_VAL)) chk_i (.*);

/* File: bench/pcrb_tb_top.sv */
module pcrb_tb_top;
timeunit 1ns;
timeprecision 1ps;
import pcrb_pkg::*;
   // identity value is arbitrary
   localparam logic [63:0] PID = 64'h0000_0000_0000_5a5a;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, smi_n = 0, ini_n = 1, err;
   logic [11:0] addr = 12'h0;
   logic [63:0] wd = 64'h0, rdat, cyc, icb, hpc, cyc_f;
   int num_errors = 0, checks = 0;
   always #12.5 clk = ~clk;
   pcrb_top #(.MODEL(4'h2), .PLATFORM_ID_VAL(PID)) uut (.core_clk_in(clk),
      .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .reg_err_out(err), .sys_mgmt_irq_strap_pin_n_in(smi_n),
      .init_strap_pin_n_in(ini_n), .cycle_count_out(cyc),
      .interrupt_ctrl_base_out(icb), .hard_poweron_config_out(hpc));
   pcrb_top #(.MODEL(PCRB_MODEL_FULL_A), .PLATFORM_ID_VAL(PID)) uut_full (
      .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(),
      .reg_err_out(), .sys_mgmt_irq_strap_pin_n_in(smi_n),
      .init_strap_pin_n_in(ini_n), .cycle_count_out(cyc_f),
      .interrupt_ctrl_base_out(), .hard_poweron_config_out());
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [63:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [11:0] a, input logic [63:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat, exp);
   endtask
   task automatic stop_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #100us;
      num_errors++;
      stop_test;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      wreg(PCRB_HPC_IDX, 64'hffff_ffff_ffff_fffc);
      chk(hpc, 64'hffff_ffff_ffff_fffd);
      wreg(PCRB_CYC_IDX, 64'hffff_ffff_1234_5678);
      chk(cyc, 64'h0000_0000_1234_5678);
      chk(cyc_f, 64'hffff_ffff_1234_5678);
      rreg(PCRB_CYC_IDX, 64'h0000_0000_1234_5679);
      wreg(PCRB_ICB_IDX, 64'h0000_0000_fee0_0900);
      rreg(PCRB_ICB_IDX, 64'h0000_0000_fee0_0900);
      chk(icb, 64'h0000_0000_fee0_0900);
      wreg(PCRB_PLAT_IDX, 64'h1111_2222_3333_4444);
      rreg(PCRB_PLAT_IDX, PID);
      rreg(12'h3ff, 64'h0);
      chk({63'h0, err}, 64'h1);
      @(posedge clk);
      rst_n <= 1'b0;
      smi_n <= 1'b1;
      ini_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({62'h0, hpc[1:0]}, 64'h2);
      stop_test;
   end
endmodule

/* File: core/pcrb_strap_sync.sv */
module pcrb_strap_sync
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // pin and synced level
   input wire logic pin_in,
   output logic level_out
);
   import pcrb_pkg::*;

   logic [PCRB_SYNC_DEPTH-1:0] sync_ff;
   logic [PCRB_SYNC_DEPTH-1:0] nxt_sync;
   logic level_ff;
   logic nxt_level;

   ////////////////////////////////////////////////////////////////////////
   // three stages; change counts once stages two and three agree
   always_comb
   begin
      nxt_sync = {sync_ff[PCRB_SYNC_DEPTH-2:0], pin_in};
      nxt_level = level_ff;
      if (sync_ff[1] == sync_ff[2])
      begin
         nxt_level = sync_ff[2];
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      sync_ff <= nxt_sync;
      level_ff <= nxt_level;
   end

   assign level_out = level_ff;
endmodule

/* File: core/pcrb_top.sv */
// Design decision made here: strobed register access.
module pcrb_top
#(
   parameter logic [3:0] MODEL = 4'h3,
   parameter logic [63:0] PLATFORM_ID_VAL = 64'h0000_0000_0000_0000
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [pcrb_pkg::PCRB_AW-1:0] reg_addr_in,
   input wire logic [pcrb_pkg::PCRB_DW-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [pcrb_pkg::PCRB_DW-1:0] reg_rdata_out,
   output logic reg_err_out,
   // strap pins, active low
   input wire logic sys_mgmt_irq_strap_pin_n_in,
   input wire logic init_strap_pin_n_in,
   // state
   output logic [pcrb_pkg::PCRB_DW-1:0] cycle_count_out,
   output logic [pcrb_pkg::PCRB_DW-1:0] interrupt_ctrl_base_out,
   output logic [pcrb_pkg::PCRB_DW-1:0] hard_poweron_config_out
);
   import pcrb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // strap synchronisers
   logic smi_lvl;
   logic init_lvl;

   pcrb_strap_sync u_sync_smi
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(sys_mgmt_irq_strap_pin_n_in),
      .level_out(smi_lvl)
   );

   pcrb_strap_sync u_sync_init
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(init_strap_pin_n_in),
      .level_out(init_lvl)
   );

   ////////////////////////////////////////////////////////////////////////
   // access decode
   function automatic logic hit(input logic [PCRB_AW-1:0] a,
                                input logic [PCRB_AW-1:0] idx);
      hit = (a == idx);
   endfunction

   // index names a modelled register
   function automatic logic mapped(input logic [PCRB_AW-1:0] a);
      mapped = hit(a, PCRB_CYC_IDX) ||
               hit(a, PCRB_PLAT_IDX) ||
               hit(a, PCRB_ICB_IDX) ||
               hit(a, PCRB_HPC_IDX) ||
               hit(a, PCRB_MON_LINE_IDX) ||
               hit(a, PCRB_MC_ADDR_IDX) ||
               hit(a, PCRB_MC_TYPE_IDX);
   endfunction

   // new value with the read-only bits of the old one kept
   function automatic logic [PCRB_DW-1:0] merge_ro(
      input logic [PCRB_DW-1:0] old_val,
      input logic [PCRB_DW-1:0] new_val,
      input logic [PCRB_DW-1:0] ro_mask);
      merge_ro = (new_val & ~ro_mask) | (old_val & ro_mask);
   endfunction

   // counter value left by a software write
   function automatic logic [PCRB_DW-1:0] cyc_wr_val(
      input logic full,
      input logic [PCRB_DW-1:0] d);
      if (full)
      begin
         cyc_wr_val = d;
      end
      else
      begin
         cyc_wr_val = {32'h0000_0000, d[PCRB_HALF-1:0]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write strobes per register and bad index flag
   logic full_wr;
   logic wr_cyc;
   logic wr_icb;
   logic wr_hpc;
   logic wr_mon;
   logic acc_bad;

   assign full_wr = (MODEL == PCRB_MODEL_FULL_A) ||
                    (MODEL == PCRB_MODEL_FULL_B);
   assign wr_cyc = reg_wr_in && hit(reg_addr_in, PCRB_CYC_IDX);
   assign wr_icb = reg_wr_in && hit(reg_addr_in, PCRB_ICB_IDX);
   assign wr_hpc = reg_wr_in && hit(reg_addr_in, PCRB_HPC_IDX);
   assign wr_mon = reg_wr_in && hit(reg_addr_in, PCRB_MON_LINE_IDX);
   // writes to identity and machine-check indices are dropped
   assign acc_bad = (reg_wr_in || reg_rd_in) && !mapped(reg_addr_in);

   ////////////////////////////////////////////////////////////////////////
   // marks the first cycle after reset release
   logic in_rst_ff;
   logic nxt_in_rst;

   always_comb
   begin
      nxt_in_rst = 1'b0;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         in_rst_ff <= 1'b1;
      end
      else
      begin
         in_rst_ff <= nxt_in_rst;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // free-running cycle counter; a write wins over the increment
   logic [63:0] cyc_ff;
   logic [63:0] nxt_cyc;

   always_comb
   begin
      nxt_cyc = cyc_ff + 64'h0000_0000_0000_0001;
      if (wr_cyc)
      begin
         nxt_cyc = cyc_wr_val(full_wr, reg_wdata_in);
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         cyc_ff <= PCRB_ZERO64;
      end
      else
      begin
         cyc_ff <= nxt_cyc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt controller base, plain read and write
   logic [63:0] icb_ff;
   logic [63:0] nxt_icb;

   always_comb
   begin
      nxt_icb = icb_ff;
      if (wr_icb)
      begin
         nxt_icb = reg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         icb_ff <= PCRB_ICB_RST;
      end
      else
      begin
         icb_ff <= nxt_icb;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // monitor line size, plain read and write
   logic [63:0] mon_ff;
   logic [63:0] nxt_mon;

   always_comb
   begin
      nxt_mon = mon_ff;
      if (wr_mon)
      begin
         nxt_mon = reg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         mon_ff <= PCRB_MON_RST;
      end
      else
      begin
         mon_ff <= nxt_mon;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // hard power-on config: strap bits read only, the rest writable
   logic [63:0] hpc_ff;
   logic [63:0] nxt_hpc;

   always_comb
   begin
      nxt_hpc = hpc_ff;
      // capture straps on the first cycle after reset release
      if (in_rst_ff)
      begin
         nxt_hpc[PCRB_HPC_TRI_BIT] = ~smi_lvl;
         nxt_hpc[PCRB_HPC_BUILTIN_SELF_TEST_BIT] = ~init_lvl;
      end
      if (wr_hpc)
      begin
         nxt_hpc = merge_ro(nxt_hpc, reg_wdata_in, PCRB_HPC_RO_MASK);
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         hpc_ff <= PCRB_HPC_RST;
      end
      else
      begin
         hpc_ff <= nxt_hpc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the read strobe, zero otherwise
   logic [63:0] rdata_ff;
   logic [63:0] nxt_rdata;

   always_comb
   begin
      nxt_rdata = PCRB_ZERO64;
      if (reg_rd_in)
      begin
         unique case (1'b1)
            hit(reg_addr_in, PCRB_CYC_IDX): nxt_rdata = cyc_ff;
            hit(reg_addr_in, PCRB_PLAT_IDX):
               nxt_rdata = PLATFORM_ID_VAL;
            hit(reg_addr_in, PCRB_ICB_IDX): nxt_rdata = icb_ff;
            hit(reg_addr_in, PCRB_HPC_IDX): nxt_rdata = hpc_ff;
            hit(reg_addr_in, PCRB_MON_LINE_IDX): nxt_rdata = mon_ff;
            hit(reg_addr_in, PCRB_MC_ADDR_IDX): nxt_rdata = PCRB_ZERO64;
            hit(reg_addr_in, PCRB_MC_TYPE_IDX): nxt_rdata = PCRB_ZERO64;
            default: nxt_rdata = PCRB_ZERO64;
         endcase
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         rdata_ff <= PCRB_ZERO64;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one-cycle pulse after an access to an unmapped index
   logic err_ff;
   logic nxt_err;

   always_comb
   begin
      nxt_err = acc_bad;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         err_ff <= 1'b0;
      end
      else
      begin
         err_ff <= nxt_err;
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign reg_err_out = err_ff;
   assign cycle_count_out = cyc_ff;
   assign interrupt_ctrl_base_out = icb_ff;
   assign hard_poweron_config_out = hpc_ff;
endmodule

/* File: pkg/pcrb_pkg.sv */
package pcrb_pkg;
   // register indices (64-bit registers, software index space)
   localparam logic [11:0] PCRB_MC_ADDR_IDX = 12'h000;
   localparam logic [11:0] PCRB_MC_TYPE_IDX = 12'h001;
   localparam logic [11:0] PCRB_MON_LINE_IDX = 12'h006;
   localparam logic [11:0] PCRB_CYC_IDX = 12'h010;
   localparam logic [11:0] PCRB_PLAT_IDX = 12'h017;
   localparam logic [11:0] PCRB_ICB_IDX = 12'h01b;
   localparam logic [11:0] PCRB_HPC_IDX = 12'h02a;
   // widths
   localparam int PCRB_AW = 12;
   localparam int PCRB_DW = 64;
   localparam int PCRB_HALF = 32;
   // model numbers that allow full-width counter writes
   localparam logic [3:0] PCRB_MODEL_FULL_A = 4'h3;
   localparam logic [3:0] PCRB_MODEL_FULL_B = 4'h4;
   // hard power-on config field positions
   localparam int PCRB_HPC_TRI_BIT = 0;
   localparam int PCRB_HPC_BUILTIN_SELF_TEST_BIT = 1;
   localparam logic [63:0] PCRB_HPC_RO_MASK = 64'h0000_0000_0000_0003;
   // reset values
   localparam logic [63:0] PCRB_ZERO64 = 64'h0000_0000_0000_0000;
   localparam logic [63:0] PCRB_ICB_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] PCRB_HPC_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] PCRB_MON_RST = 64'h0000_0000_0000_0000;
   // strap synchroniser depth
   localparam int PCRB_SYNC_DEPTH = 3;
endpackage
